// File: common/spi_slave_defs.vh
`ifndef SPI_SLAVE_DEFS_VH
`define SPI_SLAVE_DEFS_VH

`define SPI_OP_WRITE 8'h02
`define SPI_OP_FREAD 8'h0B
`define SPI_DIR_INC 2'h0
`define SPI_DIR_RSVD 2'h1
`define SPI_DIR_DEC 2'h2
`define SPI_DIR_STATIC 2'h3
`define SPI_DIR_HI 15
`define SPI_DIR_LO 14
`define SPI_AW 14
`define SPI_WIDE_BIT 13
`define SPI_EVT_ADDR 14'h0010
`define SPI_EVT_W 8
`define SPI_FIFO_DEPTH 16
`define SPI_BYTE_LAST 4'h7
`define SPI_ADDR_LAST 4'hF

`endif

// File: hdl/spi_word_fifo.v
`default_nettype none
module spi_word_fifo #(
	parameter WIDTH = 50,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	// Clock and reset.
	input wire clk,
	input wire rst,
	// Filling side.
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// Draining side.
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW:0] wr_q;
reg [AW:0] rd_q;
wire empty = (wr_q == rd_q);
wire full = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);

assign in_ready = !full;
assign out_valid = !empty;
assign out_data = mem[rd_q[AW-1:0]];

always @(posedge clk) begin
	if (in_valid && !full) begin
		mem[wr_q[AW-1:0]] <= in_data;
	end
end

always @(posedge clk) begin
	if (rst) begin
		wr_q <= {(AW+1){1'b0}};
		rd_q <= {(AW+1){1'b0}};
	end else begin
		if (in_valid && !full) begin
			wr_q <= wr_q + {{AW{1'b0}}, 1'b1};
		end
		if (out_ready && !empty) begin
			rd_q <= rd_q + {{AW{1'b0}}, 1'b1};
		end
	end
end

endmodule // spi_word_fifo
`default_nettype wire

// File: hdl/spi_evt_flags.v
`default_nettype none
module spi_evt_flags #(
	parameter W = 8
) (
	// Clock and reset.
	input wire clk,
	input wire rst,
	// Hardware event pulses.
	input wire [W-1:0] hw_event,
	// Read control from the serial engine.
	input wire snap,
	input wire clear,
	input wire abort,
	// Flag state.
	output wire [W-1:0] flags
);

reg [W-1:0] flags_q;
reg [W-1:0] pend_q;
reg [W-1:0] seen_q;
reg win_q;
reg apply_q;
wire hold = win_q | snap | clear;
wire [W-1:0] flags_d;
wire [W-1:0] pend_d;

// Events in the read window wait, then land after the clear or after an abort of the window.
assign pend_d = (apply_q ? {W{1'b0}} : pend_q) | (hold ? hw_event : {W{1'b0}});
assign flags_d = clear ? (flags_q & ~seen_q) :
	(flags_q | (apply_q ? pend_q : {W{1'b0}}) | (hold ? {W{1'b0}} : hw_event));
assign flags = flags_q;

always @(posedge clk) begin
	if (rst) begin
		flags_q <= {W{1'b0}};
		pend_q <= {W{1'b0}};
		seen_q <= {W{1'b0}};
		win_q <= 1'b0;
		apply_q <= 1'b0;
	end else begin
		flags_q <= flags_d;
		pend_q <= pend_d;
		if (snap) begin
			seen_q <= flags_q;
		end
		win_q <= snap | (win_q & ~clear & ~abort);
		apply_q <= clear | (abort & win_q);
	end
end

endmodule // spi_evt_flags
`default_nettype wire

// File: hdl/spi_slave_write_csr_access.v
`include "spi_slave_defs.vh"
`default_nettype none
module spi_slave_write_csr_access #(
	parameter AW = `SPI_AW,
	parameter EVW = `SPI_EVT_W,
	parameter DEPTH = `SPI_FIFO_DEPTH,
	parameter DEPTH_AW = 4
) (
	// Clock and reset.
	input wire clk,
	input wire rst,
	// Serial link pins.
	input wire cs_n_pin,
	input wire sclk_pin,
	input wire serial_in_line,
	output wire sdo_out,
	output wire sdo_oe,
	// Register write commits.
	output wire wr_valid,
	input wire wr_ready,
	output wire [AW-1:0] wr_addr,
	output wire [31:0] wr_data,
	output wire [3:0] wr_strb,
	// Register read access.
	output wire [AW-1:0] rd_addr,
	input wire [31:0] rd_data,
	output wire rd_effect,
	output wire [AW-1:0] rd_effect_addr,
	// Clear-on-read event flags.
	input wire [EVW-1:0] hw_event,
	output wire [EVW-1:0] evt_flags
);

////////////////////////////////////////////////////////////////////////////
localparam [6:0] S_WAIT = 7'h01;
localparam [6:0] S_CMD = 7'h02;
localparam [6:0] S_ADDR = 7'h04;
localparam [6:0] S_DUMMY = 7'h08;
localparam [6:0] S_WDATA = 7'h10;
localparam [6:0] S_RDATA = 7'h20;
localparam [6:0] S_IGN = 7'h40;
localparam [AW-1:0] ONE = {{(AW-1){1'b0}}, 1'b1};
localparam FW = AW + 36;

function wide;
	input [AW-1:0] a;
	begin
		wide = a[`SPI_WIDE_BIT];
	end
endfunction

function [3:0] lane_oh;
	input [AW-1:0] a;
	begin
		lane_oh = 4'h1 << a[1:0];
	end
endfunction

function [3:0] need_mask;
	input [AW-1:0] a;
	begin
		need_mask = wide(a) ? 4'hF : lane_oh(a);
	end
endfunction

function [AW-1:0] reg_base;
	input [AW-1:0] a;
	begin
		reg_base = wide(a) ? {a[AW-1:2], 2'h0} : a;
	end
endfunction

function [7:0] pick;
	input [31:0] w;
	input [AW-1:0] a;
	begin
		pick = wide(a) ? w[{a[1:0], 3'h0} +: 8] : w[7:0];
	end
endfunction

////////////////////////////////////////////////////////////////////////////
// Two-stage synchronisers on the pins, then an edge history stage.
reg [2:0] m1_q;
reg [2:0] m2_q;
reg [2:0] p_q;
always @(posedge clk) begin
	if (rst) begin
		m1_q <= 3'h4;
		m2_q <= 3'h4;
		p_q <= 3'h4;
	end else begin
		m1_q <= {cs_n_pin, sclk_pin, serial_in_line};
		m2_q <= m1_q;
		p_q <= m2_q;
	end
end
wire cs_n = m2_q[2];
wire sdi = m2_q[0];
wire sck_rise = m2_q[1] & ~p_q[1];
wire sck_fall = ~m2_q[1] & p_q[1];
wire cs_rise = m2_q[2] & ~p_q[2];

////////////////////////////////////////////////////////////////////////////
reg [6:0] state_q;
reg [3:0] cnt_q;
reg [15:0] sin_q;
reg op_wr_q;
reg [1:0] dir_q;
reg [AW-1:0] addr_q;
reg [AW-1:0] wbase_q;
reg [3:0] wmask_q;
reg [31:0] wbuf_q;
reg cm_valid_q;
reg [FW-1:0] cm_q;
reg [1:0] ld_q;
reg [AW-1:0] rd_addr_q;
reg [AW-1:0] rbase_q;
reg [3:0] rmask_q;
reg [31:0] snap_q;
reg [7:0] shout_q;
reg sdo_q;
reg oe_q;
reg eff_q;
reg [AW-1:0] eff_addr_q;
reg evt_snap_q;
reg evt_clr_q;

wire [7:0] sin8 = {sin_q[6:0], sdi};
wire [15:0] sin16 = {sin_q[14:0], sdi};
wire [AW-1:0] cur_base = reg_base(addr_q);
wire [3:0] cur_lane = lane_oh(addr_q);
wire [3:0] cur_need = need_mask(addr_q);
wire w_cont = (wmask_q != 4'h0) && (wbase_q == cur_base);
wire [3:0] wmask_new = (w_cont ? wmask_q : 4'h0) | cur_lane;
wire w_full = ((wmask_new & cur_need) == cur_need);
wire r_cont = (rmask_q != 4'h0) && (rbase_q == cur_base);
wire r_done = (rmask_q != 4'h0) && ((rmask_q & cur_need) == cur_need);
wire evt_sel = (cur_base == `SPI_EVT_ADDR);
wire [31:0] rsrc = evt_sel ? {{(32-EVW){1'b0}}, evt_flags} : rd_data;
wire [7:0] rbyte = pick(r_cont ? snap_q : rsrc, addr_q);
wire byte_end = sck_rise && (cnt_q == `SPI_BYTE_LAST);
wire [AW-1:0] step_addr = (dir_q == `SPI_DIR_DEC) ? addr_q - ONE :
	(dir_q == `SPI_DIR_STATIC) ? addr_q : addr_q + ONE;
wire fifo_in_ready;
wire [31:0] wbuf_new;

// Each incoming byte lands in its lane of the assembly word.
genvar gi;
generate
	for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
		assign wbuf_new[gi*8 +: 8] = cur_lane[gi] ? sin8 :
			(w_cont ? wbuf_q[gi*8 +: 8] : 8'h00);
	end
endgenerate

////////////////////////////////////////////////////////////////////////////
// Frame sequencer.
always @(posedge clk) begin
	if (rst) begin
		state_q <= S_WAIT;
		cnt_q <= 4'h0;
		sin_q <= 16'h0000;
		op_wr_q <= 1'b0;
		dir_q <= 2'h0;
		addr_q <= {AW{1'b0}};
		wbase_q <= {AW{1'b0}};
		wmask_q <= 4'h0;
		wbuf_q <= 32'h00000000;
		cm_valid_q <= 1'b0;
		cm_q <= {FW{1'b0}};
		ld_q <= 2'h0;
		rd_addr_q <= {AW{1'b0}};
		rbase_q <= {AW{1'b0}};
		rmask_q <= 4'h0;
		snap_q <= 32'h00000000;
		shout_q <= 8'h00;
		sdo_q <= 1'b0;
		oe_q <= 1'b0;
		eff_q <= 1'b0;
		eff_addr_q <= {AW{1'b0}};
		evt_snap_q <= 1'b0;
		evt_clr_q <= 1'b0;
	end else begin
		eff_q <= 1'b0;
		evt_snap_q <= 1'b0;
		evt_clr_q <= 1'b0;
		if (cm_valid_q && fifo_in_ready) begin
			cm_valid_q <= 1'b0;
		end
		if (cs_n) begin
			state_q <= S_CMD;
			cnt_q <= 4'h0;
			wmask_q <= 4'h0;
			rmask_q <= 4'h0;
			ld_q <= 2'h0;
			oe_q <= 1'b0;
		end else begin
			if (sck_rise) begin
				sin_q <= sin16;
				cnt_q <= cnt_q + 4'h1;
			end
			case (state_q)
			S_CMD: begin
				if (byte_end) begin
					cnt_q <= 4'h0;
					op_wr_q <= (sin8 == `SPI_OP_WRITE);
					if (sin8 == `SPI_OP_WRITE || sin8 == `SPI_OP_FREAD) begin
						state_q <= S_ADDR;
					end else begin
						state_q <= S_IGN;
					end
				end
			end
			S_ADDR: begin
				if (sck_rise && cnt_q == `SPI_ADDR_LAST) begin
					cnt_q <= 4'h0;
					dir_q <= sin16[`SPI_DIR_HI:`SPI_DIR_LO];
					addr_q <= sin16[AW-1:0];
					if (op_wr_q) begin
						state_q <= S_WDATA;
					end else begin
						state_q <= S_DUMMY;
					end
				end
			end
			S_DUMMY: begin
				if (byte_end) begin
					cnt_q <= 4'h0;
					state_q <= S_RDATA;
					ld_q <= 2'h1;
				end
			end
			S_WDATA: begin
				if (byte_end) begin
					cnt_q <= 4'h0;
					addr_q <= step_addr;
					if (w_full) begin
						wmask_q <= 4'h0;
						cm_valid_q <= 1'b1;
						cm_q <= {cur_base, cur_need, wbuf_new};
					end else begin
						wmask_q <= wmask_new;
						wbase_q <= cur_base;
						wbuf_q <= wbuf_new;
					end
				end
			end
			S_RDATA: begin
				if (sck_fall) begin
					sdo_q <= shout_q[7];
					shout_q <= {shout_q[6:0], 1'b0};
					oe_q <= 1'b1;
				end
				if (byte_end) begin
					cnt_q <= 4'h0;
					addr_q <= step_addr;
					ld_q <= 2'h1;
					if (r_done) begin
						eff_q <= 1'b1;
						eff_addr_q <= rbase_q;
						evt_clr_q <= (rbase_q == `SPI_EVT_ADDR);
						rmask_q <= 4'h0;
					end
				end
				if (ld_q == 2'h1) begin
					rd_addr_q <= cur_base;
					ld_q <= 2'h2;
				end
				if (ld_q == 2'h2) begin
					ld_q <= 2'h0;
					shout_q <= rbyte;
					if (r_cont) begin
						rmask_q <= rmask_q | cur_lane;
					end else begin
						snap_q <= rsrc;
						rbase_q <= cur_base;
						rmask_q <= cur_lane;
						evt_snap_q <= evt_sel;
					end
				end
			end
			S_IGN: begin
				cnt_q <= 4'h0;
			end
			S_WAIT: begin
				cnt_q <= 4'h0;
			end
			default: begin
				state_q <= S_WAIT;
			end
			endcase
		end
	end
end

////////////////////////////////////////////////////////////////////////////
// Committed writes wait here until the register side takes them.
wire [FW-1:0] fifo_out;
spi_word_fifo #(
	.WIDTH(FW),
	.DEPTH(DEPTH),
	.AW(DEPTH_AW)
) u_fifo (
	.clk(clk),
	.rst(rst),
	.in_valid(cm_valid_q),
	.in_ready(fifo_in_ready),
	.in_data(cm_q),
	.out_valid(wr_valid),
	.out_ready(wr_ready),
	.out_data(fifo_out)
);
assign wr_addr = fifo_out[FW-1:36];
assign wr_strb = fifo_out[35:32];
assign wr_data = fifo_out[31:0];

////////////////////////////////////////////////////////////////////////////
// Clear-on-read event register.
spi_evt_flags #(
	.W(EVW)
) u_evt (
	.clk(clk),
	.rst(rst),
	.hw_event(hw_event),
	.snap(evt_snap_q),
	.clear(evt_clr_q),
	.abort(cs_rise),
	.flags(evt_flags)
);

assign sdo_out = sdo_q;
assign sdo_oe = oe_q;
assign rd_addr = rd_addr_q;
assign rd_effect = eff_q;
assign rd_effect_addr = eff_addr_q;

endmodule // spi_slave_write_csr_access
`default_nettype wire

// File: verif/spi_csr_props.sv
`default_nettype none
module spi_csr_props #(
	parameter AW = 14,
	parameter EVW = 8
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Watched ports.
	input wire logic cs_n_pin,
	input wire logic wr_valid,
	input wire logic wr_ready,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [31:0] wr_data,
	input wire logic [3:0] wr_strb,
	input wire logic rd_effect,
	input wire logic [EVW-1:0] hw_event,
	input wire logic [EVW-1:0] evt_flags
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_wide;
		wr_valid && wr_addr[13] |-> wr_strb == 4'hF && wr_addr[1:0] == 2'h0;
	endproperty
	a_wide: assert property (p_wide) else $error("wide commit partial");
	property p_byte;
		wr_valid && !wr_addr[13] |-> wr_strb == 4'h1 << wr_addr[1:0];
	endproperty
	a_byte: assert property (p_byte) else $error("byte lane wrong");
	property p_hold;
		wr_valid && !wr_ready |=> wr_valid && $stable(wr_addr) && $stable(wr_data);
	endproperty
	a_hold: assert property (p_hold) else $error("commit lost");
	property p_in_frame;
		$rose(wr_valid) |-> !cs_n_pin;
	endproperty
	a_in_frame: assert property (p_in_frame) else $error("late commit");
	property p_pulse;
		rd_effect |=> !rd_effect;
	endproperty
	a_pulse: assert property (p_pulse) else $error("effect too long");
	property p_eff_sel;
		rd_effect |-> !cs_n_pin;
	endproperty
	a_eff_sel: assert property (p_eff_sel) else $error("effect outside");
	property p_kept;
		hw_event[0] |-> ##[1:400] evt_flags[0];
	endproperty
	a_kept: assert property (p_kept) else $error("event lost");
	property p_clear;
		$fell(evt_flags[0]) |-> $past(rd_effect) || $past(rd_effect, 2);
	endproperty
	a_clear: assert property (p_clear) else $error("flag cleared alone");
endmodule // spi_csr_props
`default_nettype wire

// File: verif/spi_host_model.sv
`default_nettype none
module spi_host_model (
	// Clock that paces the pins.
	input wire logic clk,
	// Serial pins.
	output var logic cs_n,
	output var logic sclk,
	output var logic mosi,
	input wire logic miso
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		mosi = 1'b0;
	end
	// Each half period of the serial clock lasts 20 cycles.
	task put(input logic [7:0] b, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			mosi <= b[i];
			repeat (20) @(posedge clk);
			sclk <= 1'b1;
			r[i] = miso;
			repeat (20) @(posedge clk);
			sclk <= 1'b0;
		end
	endtask
	task start(input logic [7:0] op, input logic [15:0] a);
		logic [7:0] r;
		@(posedge clk);
		cs_n <= 1'b0;
		repeat (20) @(posedge clk);
		put(op, r);
		put(a[15:8], r);
		put(a[7:0], r);
	endtask
	task stop;
		repeat (20) @(posedge clk);
		cs_n <= 1'b1;
		mosi <= ~mosi;
		repeat (75) @(posedge clk);
	endtask
endmodule // spi_host_model
`default_nettype wire

// File: verif/spi_slave_write_csr_access_bench.sv
`default_nettype none
module spi_slave_write_csr_access_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0, rst = 1'b1, wr_ready = 1'b1, hold = 1'b0;
	logic cs_n, sclk, mosi, sdo_out, sdo_oe, wr_valid, rd_effect;
	logic [13:0] wr_addr, rd_addr, rd_effect_addr;
	logic [31:0] wr_data, rd_data;
	logic [3:0] wr_strb;
	logic [7:0] hw_event = 8'h00, evt_flags, salt = 8'h00;
	logic [49:0] exp_q[$], got_q[$];
	logic [13:0] eaddr = 14'h0000;
	int bad_count = 0, check_count = 0, eff = 0, cyc = 0;
	always #2 clk = ~clk;
	function automatic logic [7:0] rb(input logic [13:0] x, logic [7:0] s);
		return x[7:0] ^ 8'h5A ^ s;
	endfunction
	function automatic logic [31:0] rw(input logic [13:0] a, logic [7:0] s);
		for (int i = 0; i < 4; i++)
			rw[8*i+:8] = rb(a[13] ? {a[13:2], 2'(i)} : a, s);
	endfunction
	function automatic logic [13:0] nxt(input logic [13:0] x, logic [1:0] d);
		return d == 2'h2 ? x - 14'h1 : d == 2'h3 ? x : x + 14'h1;
	endfunction
	assign rd_data = rw(rd_addr, salt);
	spi_slave_write_csr_access DUT (.clk(clk), .rst(rst), .cs_n_pin(cs_n),
		.sclk_pin(sclk), .serial_in_line(mosi), .sdo_out(sdo_out),
		.sdo_oe(sdo_oe), .wr_valid(wr_valid), .wr_ready(wr_ready),
		.wr_addr(wr_addr), .wr_data(wr_data), .wr_strb(wr_strb),
		.rd_addr(rd_addr), .rd_data(rd_data), .rd_effect(rd_effect),
		.rd_effect_addr(rd_effect_addr), .hw_event(hw_event),
		.evt_flags(evt_flags));
	spi_host_model host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .mosi(mosi),
		.miso(sdo_oe ? sdo_out : 1'b1));
	always @(posedge clk) begin
		cyc <= cyc + 1;
		wr_ready <= hold ? 1'b0 : ($urandom % 4) != 0;
		if (wr_valid && wr_ready) got_q.push_back({wr_addr, wr_strb, wr_data &
			{{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}}});
		if (rd_effect) begin
			eff++;
			eaddr <= rd_effect_addr;
		end
		if (cyc == 95000) begin
			bad_count++;
			end_of_test();
		end
	end
	task cmp(input string n, input logic [49:0] e, g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task drain;
		repeat (60) @(posedge clk);
		while (exp_q.size() > 0)
			cmp("write", exp_q.pop_front(), got_q.size() ? got_q.pop_front() : 'x);
		cmp("extra", 50'h0, 50'(got_q.size()));
		got_q.delete();
	endtask
	task wframe(input logic [7:0] op, input logic [15:0] a, input int n);
		logic [13:0] x;
		logic [7:0] d, r;
		logic [31:0] w;
		x = a[13:0];
		w = 32'h0;
		host.start(op, a);
		for (int i = 0; i < n; i++) begin
			d = 8'($urandom);
			host.put(d, r);
			if (op == 8'h02 && !x[13])
				exp_q.push_back({x, 4'h1 << x[1:0], 32'(d) << {x[1:0], 3'h0}});
			w[{x[1:0], 3'h0}+:8] = d;
			x = nxt(x, a[15:14]);
		end
		if (op == 8'h02 && a[13] && n == 4)
			exp_q.push_back({a[13:2], 2'h0, 4'hF, w});
		host.stop();
	endtask
	task rframe(input logic [15:0] a, input int n, chg, ne);
		logic [13:0] x, la, eb;
		logic [7:0] r, es;
		int e0;
		x = a[13:0];
		la = x;
		e0 = eff;
		es = salt;
		host.start(8'h0B, a);
		host.put(8'($urandom), r);
		for (int i = 0; i < n; i++) begin
			host.put(8'($urandom), r);
			cmp("read", {42'h0, rb(x, es)}, {42'h0, r});
			cmp("drive", 50'h1, {49'h0, sdo_oe});
			if (i == chg) salt = ~salt;
			la = x;
			x = nxt(x, a[15:14]);
		end
		host.stop();
		cmp("effects", 50'(ne), 50'(eff - e0));
		cmp("float", 50'h0, {49'h0, sdo_oe});
		eb = la[13] ? {la[13:2], 2'h0} : la;
		if (ne > 0)
			cmp("effect addr", 50'(eb), 50'(eaddr));
	endtask
	task ev(input logic [7:0] v);
		@(posedge clk);
		hw_event <= v;
		@(posedge clk);
		hw_event <= 8'h00;
		repeat (4) @(posedge clk);
	endtask
	task evrd(input logic [7:0] v, er, ef);
		logic [7:0] r;
		host.start(8'h0B, 16'h0010);
		host.put(8'h00, r);
		fork
			host.put(8'h00, r);
			begin
				#640;
				ev(v);
			end
		join
		host.stop();
		cmp("flag read", {42'h0, er}, {42'h0, r});
		cmp("flags", {42'h0, ef}, {42'h0, evt_flags});
	endtask
	initial begin
		logic [7:0] v;
		void'($urandom(44));
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		repeat (10) @(posedge clk);
		for (int i = 0; i < 24; i++)
			wframe(8'h02, {2'(i), 14'h0100 + 14'($urandom % 4096)},
				1 + $urandom % 3);
		drain();
		wframe(8'h02, 16'h2004, 4);
		wframe(8'h02, 16'hA00B, 4);
		wframe(8'h02, 16'h2010, 2);
		wframe(8'h03, 16'h0120, 3);
		drain();
		hold <= 1'b1;
		wframe(8'h02, 16'hC300, 16);
		cmp("full", 50'h1, {49'h0, wr_valid});
		hold <= 1'b0;
		drain();
		for (int d = 0; d < 4; d++)
			rframe({2'(d), 14'h0104}, 3, -1, 3);
		rframe(16'h2008, 4, 0, 1);
		rframe(16'h2008, 2, -1, 0);
		v = 8'($urandom) | 8'h01;
		ev(v);
		evrd(8'h00, v, 8'h00);
		ev(8'h01);
		evrd(8'h03, 8'h01, 8'h03);
		end_of_test();
	end
endmodule // spi_slave_write_csr_access_bench
bind spi_slave_write_csr_access spi_csr_props #(.AW(AW), .EVW(EVW)) u_props (
	.clk(clk), .rst(rst), .cs_n_pin(cs_n_pin), .wr_valid(wr_valid),
	.wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
	.wr_strb(wr_strb), .rd_effect(rd_effect), .hw_event(hw_event),
	.evt_flags(evt_flags));
`default_nettype wire
